// [hdl/vic_pkg.sv]
// constants, states and carrier types of the vectored interrupt controller
package vic_pkg;
  localparam int VIC_NSRC = 6;
  localparam int VIC_AW = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0] VIC_IDX_CTRL = 8'hF0;
  localparam logic [7:0] VIC_IDX_PINS = 8'hF1;
  localparam logic [7:0] VIC_IDX_STAT = 8'hF2;
  localparam logic [7:0] VIC_IDX_PRIO = 8'hF9;
  localparam logic [7:0] VIC_IDX_REQ = 8'hFA;
  localparam logic [7:0] VIC_IDX_MASK = 8'hFB;
  // field positions
  localparam int VIC_REQ_SEL_C = 7;
  localparam int VIC_REQ_SEL_A = 6;
  localparam int VIC_CTRL_GIE = 0;
  localparam int VIC_SRC_A = 0;
  localparam int VIC_SRC_B = 1;
  localparam int VIC_SRC_C = 2;
  localparam int VIC_SRC_WIDE = 3;
  localparam int VIC_SRC_NARROW = 4;
  localparam int VIC_SRC_VM = 5;
  // reset values
  localparam logic [7:0] VIC_REQ_RST = 8'h00;
  localparam logic [5:0] VIC_MASK_RST = 6'h00;
  localparam logic [2:0] VIC_PRIO_RST = 3'h0;
  localparam logic VIC_GIE_RST = 1'b0;
  // vector table base in program memory, two bytes per source
  localparam logic [15:0] VIC_VEC_BASE = 16'h0000;

  typedef enum logic [2:0] {
    VIC_ST_IDLE = 3'b000,
    VIC_ST_SAVE = 3'b001,
    VIC_ST_HI_WAIT = 3'b010,
    VIC_ST_HI_TAKE = 3'b011,
    VIC_ST_LO_WAIT = 3'b100,
    VIC_ST_LO_TAKE = 3'b101
  } vic_state_t;

  typedef struct packed {
    logic pin_port3_bit1;
    logic pin_port3_bit2;
    logic pin_port3_bit3;
  } vic_pins_t;

  typedef struct packed {
    logic comparator_one_evt;
    logic comparator_two_evt;
    logic wide_counter_evt;
    logic narrow_counter_evt;
    logic voltage_low;
    logic vd_enable;
    logic demod_mode;
    logic demod_alt_pin;
    logic capture_evt;
  } vic_src_t;
endpackage : vic_pkg

// [hdl/vic_edge.sv]
// edge detector for one external interrupt pin
`timescale 1ns/10ps
module vic_edge import vic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic rise_en,
  input wire logic fall_en,
  output logic evt
);
  logic prev_q;
  logic prev_d;
  logic armed_q;
  logic armed_d;

  always_comb begin
    prev_d = pin;
    armed_d = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      armed_q <= armed_d;
    end
  end

  // no edge is seen in the first cycle after reset
  assign evt = armed_q & ((rise_en & pin & ~prev_q) | (fall_en & ~pin & prev_q));
endmodule : vic_edge

// [hdl/vic_prio.sv]
// programmable priority encoder over the pending sources
`timescale 1ns/10ps
module vic_prio import vic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [VIC_NSRC-1:0] pend,
  input wire logic [2:0] start,
  output logic any,
  output logic [2:0] idx
);
  function automatic logic [3:0] pick(input logic [5:0] p, input logic [2:0] s);
    logic [3:0] r;
    logic [3:0] n;
    logic [3:0] b;
    r = 4'h0;
    b = (s < 3'(VIC_NSRC)) ? {1'b0, s} : 4'h0;
    for (int k = VIC_NSRC - 1; k >= 0; k--) begin
      n = b + 4'(k);
      if (n >= 4'(VIC_NSRC)) begin
        n = n - 4'(VIC_NSRC);
      end
      if (p[n[2:0]]) begin
        r = {1'b1, n[2:0]};
      end
    end
    return r;
  endfunction : pick

  logic [3:0] res;

  always_comb begin
    res = pick(pend, start);
    any = res[3];
    idx = res[2:0];
  end

  property p_prio_pick;
    @(posedge sys_clk) disable iff (rst)
    (|pend) |-> any && pend[idx];
  endproperty
  a_prio_pick: assert property (p_prio_pick) else $error("picked source not pending");

  property p_prio_first;
    @(posedge sys_clk) disable iff (rst)
    (start < 3'(VIC_NSRC) && pend[start]) |-> idx == start;
  endproperty
  a_prio_first: assert property (p_prio_first) else $error("start source not preferred");
endmodule : vic_prio

// [hdl/vic_top.sv]
// vectored interrupt controller with avalon register slave and vector fetch
// What this block does
// - second external request latches only on falling pin edge, vector bytes 2,3.
// - first request from one pin, vector 0,1; third from other pin, vector 4,5.
// - every grant reads a 16-bit routine address from vector pair, then branches.
// - simultaneous pending requests resolved by encoder set through priority register.
// - a grant runs a machine cycle: disable interrupts, save counter and flags.
// - masked sources still latch in the request register for polling.
// - request register bits 7 and 6 choose edges of the two programmable pins.
// - first comparator feeds third request, second comparator feeds first request.
// - demodulation capture on alternate pin also raises third request; software masks it.
// - software reads the interrupt pin levels directly.
// - voltage-monitor request bit 5 holds until cleared; serviced only when unmasked.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
module vic_top import vic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [VIC_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire vic_pins_t pins,
  input wire vic_src_t src,
  input wire logic enable_interrupts_instr,
  input wire logic core_saved,
  input wire logic [7:0] pm_rdata,
  output logic irq,
  output logic int_cycle,
  output logic save_req,
  output logic pm_rd,
  output logic [15:0] pm_addr,
  output logic branch,
  output logic [15:0] isr_addr
);
  function automatic logic hit(input logic [VIC_AW-1:0] a, input logic [7:0] i);
    return (a[VIC_AW-1:2] == i) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic [15:0] vec_loc(input logic [2:0] s, input logic lo);
    return VIC_VEC_BASE + {12'h000, s, lo};
  endfunction : vec_loc

  // bus slave: one wait state, then the request completes
  logic wait_q;
  logic wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic acc;
  logic take;
  logic wr_en;

  // register file
  logic [7:0] req_q;
  logic [7:0] req_d;
  logic [5:0] mask_q;
  logic [5:0] mask_d;
  logic [2:0] prio_q;
  logic [2:0] prio_d;
  logic gie_q;
  logic gie_d;
  logic irq_q;
  logic irq_d;

  // interrupt machine cycle
  vic_state_t st_q;
  vic_state_t st_d;
  logic [2:0] srv_q;
  logic [2:0] srv_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [15:0] isr_q;
  logic [15:0] isr_d;
  logic [15:0] pm_addr_q;
  logic [15:0] pm_addr_d;
  logic pm_rd_q;
  logic pm_rd_d;
  logic save_q;
  logic save_d;
  logic cyc_q;
  logic cyc_d;
  logic branch_q;
  logic branch_d;

  logic [2:0] pin_vec;
  logic [2:0] rise_en;
  logic [2:0] fall_en;
  logic [2:0] evt;
  logic [5:0] sets;
  logic [5:0] clrs;
  logic [5:0] pend;
  logic enc_any;
  logic [2:0] enc_idx;
  logic grant;

  assign pin_vec = {pins.pin_port3_bit1, pins.pin_port3_bit3, pins.pin_port3_bit2};
  assign rise_en = {req_q[VIC_REQ_SEL_C], 1'b0, req_q[VIC_REQ_SEL_A]};
  assign fall_en = {~req_q[VIC_REQ_SEL_C] | req_q[VIC_REQ_SEL_A], 1'b1,
                    ~req_q[VIC_REQ_SEL_A] | req_q[VIC_REQ_SEL_C]};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_edge
      vic_edge u_edge (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin(pin_vec[g]),
        .rise_en(rise_en[g]),
        .fall_en(fall_en[g]),
        .evt(evt[g])
      );
    end
  endgenerate

  always_comb begin
    sets[VIC_SRC_A] = evt[0] | src.comparator_two_evt;
    sets[VIC_SRC_B] = evt[1];
    sets[VIC_SRC_C] = evt[2] | src.comparator_one_evt
                      | (src.demod_mode & src.demod_alt_pin & src.capture_evt);
    sets[VIC_SRC_WIDE] = src.wide_counter_evt;
    sets[VIC_SRC_NARROW] = src.narrow_counter_evt;
    sets[VIC_SRC_VM] = src.vd_enable & src.voltage_low;
  end

  assign pend = req_q[5:0] & mask_q;

  vic_prio u_prio (
    .sys_clk(sys_clk),
    .rst(rst),
    .pend(pend),
    .start(prio_q),
    .any(enc_any),
    .idx(enc_idx)
  );

  assign grant = (st_q == VIC_ST_IDLE) & gie_q & enc_any;
  assign acc = avs_read | avs_write;
  assign take = acc & ~wait_q;
  assign wr_en = take & avs_write & avs_byteenable[0];

  always_comb begin
    wait_d = ~(acc & wait_q);
    rdata_d = rdata_q;
    if (acc & wait_q & avs_read) begin
      rdata_d = 32'h0000_0000;
      if (hit(avs_address, VIC_IDX_REQ)) begin
        rdata_d = {24'h000000, req_q};
      end else if (hit(avs_address, VIC_IDX_MASK)) begin
        rdata_d = {26'h0000000, mask_q};
      end else if (hit(avs_address, VIC_IDX_PRIO)) begin
        rdata_d = {29'h00000000, prio_q};
      end else if (hit(avs_address, VIC_IDX_CTRL)) begin
        rdata_d = {31'h00000000, gie_q};
      end else if (hit(avs_address, VIC_IDX_PINS)) begin
        rdata_d = {29'h00000000, pin_vec};
      end else if (hit(avs_address, VIC_IDX_STAT)) begin
        rdata_d = {26'h0000000, st_q, srv_q};
      end
    end
  end

  always_comb begin
    clrs = 6'h00;
    req_d = req_q;
    mask_d = mask_q;
    prio_d = prio_q;
    gie_d = gie_q;
    if (wr_en && hit(avs_address, VIC_IDX_REQ)) begin
      clrs = avs_writedata[5:0];
      req_d[7:6] = avs_writedata[7:6];
    end
    if (wr_en && hit(avs_address, VIC_IDX_MASK)) begin
      mask_d = avs_writedata[5:0];
    end
    if (wr_en && hit(avs_address, VIC_IDX_PRIO)) begin
      prio_d = avs_writedata[2:0];
    end
    if (wr_en && hit(avs_address, VIC_IDX_CTRL)) begin
      gie_d = avs_writedata[VIC_CTRL_GIE];
    end
    if (enable_interrupts_instr) begin
      gie_d = 1'b1;
    end
    if (grant) begin
      clrs[enc_idx] = 1'b1;
      gie_d = 1'b0;
    end
    // a new event wins over a clear in the same cycle
    req_d[5:0] = (req_q[5:0] & ~clrs) | sets;
    irq_d = |pend;
  end

  always_comb begin
    st_d = st_q;
    srv_d = srv_q;
    hi_d = hi_q;
    isr_d = isr_q;
    pm_addr_d = pm_addr_q;
    pm_rd_d = 1'b0;
    save_d = save_q;
    cyc_d = cyc_q;
    branch_d = 1'b0;
    case (st_q)
      VIC_ST_IDLE: begin
        if (grant) begin
          st_d = VIC_ST_SAVE;
          srv_d = enc_idx;
          save_d = 1'b1;
          cyc_d = 1'b1;
        end
      end
      VIC_ST_SAVE: begin
        if (core_saved) begin
          save_d = 1'b0;
          pm_rd_d = 1'b1;
          pm_addr_d = vec_loc(srv_q, 1'b0);
          st_d = VIC_ST_HI_WAIT;
        end
      end
      VIC_ST_HI_WAIT: begin
        st_d = VIC_ST_HI_TAKE;
      end
      VIC_ST_HI_TAKE: begin
        hi_d = pm_rdata;
        pm_rd_d = 1'b1;
        pm_addr_d = vec_loc(srv_q, 1'b1);
        st_d = VIC_ST_LO_WAIT;
      end
      VIC_ST_LO_WAIT: begin
        st_d = VIC_ST_LO_TAKE;
      end
      VIC_ST_LO_TAKE: begin
        isr_d = {hi_q, pm_rdata};
        branch_d = 1'b1;
        cyc_d = 1'b0;
        st_d = VIC_ST_IDLE;
      end
      default: begin
        st_d = VIC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      req_q <= VIC_REQ_RST;
      mask_q <= VIC_MASK_RST;
      prio_q <= VIC_PRIO_RST;
      gie_q <= VIC_GIE_RST;
      irq_q <= 1'b0;
      st_q <= VIC_ST_IDLE;
      srv_q <= 3'h0;
      hi_q <= 8'h00;
      isr_q <= 16'h0000;
      pm_addr_q <= 16'h0000;
      pm_rd_q <= 1'b0;
      save_q <= 1'b0;
      cyc_q <= 1'b0;
      branch_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
      mask_q <= mask_d;
      prio_q <= prio_d;
      gie_q <= gie_d;
      irq_q <= irq_d;
      st_q <= st_d;
      srv_q <= srv_d;
      hi_q <= hi_d;
      isr_q <= isr_d;
      pm_addr_q <= pm_addr_d;
      pm_rd_q <= pm_rd_d;
      save_q <= save_d;
      cyc_q <= cyc_d;
      branch_q <= branch_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq = irq_q;
  assign int_cycle = cyc_q;
  assign save_req = save_q;
  assign pm_rd = pm_rd_q;
  assign pm_addr = pm_addr_q;
  assign branch = branch_q;
  assign isr_addr = isr_q;

  property p_fall_b;
    @(posedge sys_clk) disable iff (rst)
    ($past(pins.pin_port3_bit3) && !pins.pin_port3_bit3 && !$past(rst)) |=> req_q[VIC_SRC_B];
  endproperty
  a_fall_b: assert property (p_fall_b) else $error("falling edge on b not latched");

  property p_rise_a;
    @(posedge sys_clk) disable iff (rst)
    (!$past(pins.pin_port3_bit2) && pins.pin_port3_bit2 && !$past(rst)
      && req_q[VIC_REQ_SEL_A]) |=> req_q[VIC_SRC_A];
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("rising edge on a not latched");

  property p_rise_c_off;
    @(posedge sys_clk) disable iff (rst)
    (req_q[7:6] == 2'b01 && $rose(pins.pin_port3_bit1) && !$past(rst) && !req_q[VIC_SRC_C]
      && !src.comparator_one_evt && !src.capture_evt) |=> !req_q[VIC_SRC_C];
  endproperty
  a_rise_c_off: assert property (p_rise_c_off) else $error("edge select of c misread");

  property p_vec_hi;
    @(posedge sys_clk) disable iff (rst)
    (st_q == VIC_ST_SAVE && core_saved) |=> pm_rd && pm_addr == vec_loc(srv_q, 1'b0)
      ##2 pm_rd && pm_addr == vec_loc(srv_q, 1'b1);
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("vector pair address wrong");

  property p_isr;
    @(posedge sys_clk) disable iff (rst)
    branch |-> isr_addr == {$past(pm_rdata, 3), $past(pm_rdata, 1)};
  endproperty
  a_isr: assert property (p_isr) else $error("routine address not hi then lo byte");

  property p_grant;
    @(posedge sys_clk) disable iff (rst)
    grant |=> st_q == VIC_ST_SAVE && srv_q == $past(enc_idx) && !gie_q && save_req && int_cycle;
  endproperty
  a_grant: assert property (p_grant) else $error("grant did not start machine cycle");

  property p_no_grant;
    @(posedge sys_clk) disable iff (rst)
    (st_q == VIC_ST_IDLE && (!gie_q || pend == 6'h00)) |=> st_q == VIC_ST_IDLE;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("grant without enable or mask");

  property p_busy;
    @(posedge sys_clk) disable iff (rst)
    (st_q != VIC_ST_IDLE && gie_q && pend != 6'h00 && !wr_en) |=> gie_q && $stable(srv_q);
  endproperty
  a_busy: assert property (p_busy) else $error("grant during machine cycle");

  property p_masked_latch;
    @(posedge sys_clk) disable iff (rst)
    (src.wide_counter_evt && !mask_q[VIC_SRC_WIDE]) |=> req_q[VIC_SRC_WIDE];
  endproperty
  a_masked_latch: assert property (p_masked_latch) else $error("masked event lost");

  property p_comp;
    @(posedge sys_clk) disable iff (rst)
    src.comparator_one_evt |=> req_q[VIC_SRC_C];
  endproperty
  a_comp: assert property (p_comp) else $error("comparator one not routed");

  property p_capture;
    @(posedge sys_clk) disable iff (rst)
    (src.demod_mode && src.demod_alt_pin && src.capture_evt) |=> req_q[VIC_SRC_C];
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not raise c");

  property p_pins;
    @(posedge sys_clk) disable iff (rst)
    (avs_read && wait_q && hit(avs_address, VIC_IDX_PINS))
      |=> !avs_waitrequest && avs_readdata[2:0] == $past(pin_vec);
  endproperty
  a_pins: assert property (p_pins) else $error("pin levels not returned");

  property p_vm_hold;
    @(posedge sys_clk) disable iff (rst)
    (req_q[VIC_SRC_VM] && !clrs[VIC_SRC_VM]) |=> req_q[VIC_SRC_VM];
  endproperty
  a_vm_hold: assert property (p_vm_hold) else $error("voltage request dropped");
endmodule : vic_top

// [bench/vic_core_model.sv]
// core and program memory stand-in answering the save handshake and vector fetch
`timescale 1ns/10ps
module vic_core_model import vic_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] save_dly,
  input wire logic save_req,
  input wire logic pm_rd,
  input wire logic [15:0] pm_addr,
  output logic core_saved,
  output logic [7:0] pm_rdata
);
  logic [3:0] cnt_q;
  // save answer after save_dly idle cycles, one-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (rst || !save_req || core_saved) begin
      cnt_q <= 4'h0;
      core_saved <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      core_saved <= (cnt_q >= save_dly);
    end
  end
  // vector byte the cycle after a read; otherwise a changing pattern
  always_ff @(posedge sys_clk) begin
    if (rst)
      pm_rdata <= 8'h00;
    else if (pm_rd)
      pm_rdata <= pm_addr[7:0] ^ 8'hA5;
    else
      pm_rdata <= ~pm_rdata;
  end
endmodule : vic_core_model

// [bench/tb_vic_top.sv]
// self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
module tb_vic_top import vic_pkg::*;;
  logic sys_clk, rst, avs_read, avs_write, enable_interrupts_instr, core_saved;
  logic avs_waitrequest, irq, int_cycle, save_req, pm_rd, branch;
  logic [VIC_AW-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] pm_rdata;
  logic [15:0] pm_addr, isr_addr;
  logic [3:0] save_dly;
  vic_pins_t pins;
  vic_src_t src;
  int error_cnt, num_checks, e;
  logic [7:0] ridx [6] = '{VIC_IDX_REQ, VIC_IDX_MASK, VIC_IDX_PRIO, VIC_IDX_CTRL,
    VIC_IDX_STAT, 8'h20};
  logic [8:0] ev_src [8] = '{9'h100, 9'h080, 9'h007, 9'h005, 9'h040, 9'h020, 9'h018, 9'h010};
  logic [5:0] ev_exp [8] = '{6'h04, 6'h01, 6'h04, 6'h00, 6'h08, 6'h10, 6'h20, 6'h00};
  logic [5:0] pats [2] = '{6'h3F, 6'h2A};

  vic_top u_vic_top (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'hF),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins(pins), .src(src),
    .enable_interrupts_instr(enable_interrupts_instr), .core_saved(core_saved),
    .pm_rdata(pm_rdata), .irq(irq), .int_cycle(int_cycle), .save_req(save_req),
    .pm_rd(pm_rd), .pm_addr(pm_addr), .branch(branch), .isr_addr(isr_addr));

  vic_core_model u_vic_core_model (.sys_clk(sys_clk), .rst(rst), .save_dly(save_dly),
    .save_req(save_req), .pm_rd(pm_rd), .pm_addr(pm_addr), .core_saved(core_saved),
    .pm_rdata(pm_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, wd};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      results();
    end
  endtask : bus

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask : rdchk

  task automatic pulse_ei;
    @(posedge sys_clk);
    enable_interrupts_instr <= 1'b1;
    @(posedge sys_clk);
    enable_interrupts_instr <= 1'b0;
  endtask : pulse_ei

  // one-cycle events for the chosen request bits, pin b falls and returns
  task automatic raise(input logic [5:0] p);
    @(posedge sys_clk);
    src <= {p[2], p[0], p[3], p[4], p[5], p[5], 3'b000};
    pins.pin_port3_bit3 <= ~p[1];
    @(posedge sys_clk);
    src <= '0;
    pins <= 3'b111;
    tick(2);
  endtask : raise

  task automatic wait_branch(input int s);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
      seen = seen | int_cycle;
    end while (branch !== 1'b1 && n < 200);
    if (n >= 200) begin
      error_cnt++;
      results();
    end
    chk({16'h0000, isr_addr}, {16'h0000, 8'(2 * s) ^ 8'hA5, 8'(2 * s + 1) ^ 8'hA5});
    chk({30'h0, seen, int_cycle}, 32'h2);
  endtask : wait_branch

  // rotating search from the start source
  function automatic int first(input logic [5:0] p, input int s);
    for (int i = 0; i < 6; i++)
      if (p[(s + i) % 6]) return (s + i) % 6;
    return 0;
  endfunction : first

  initial begin
    error_cnt = 0;
    num_checks = 0;
    {avs_address, avs_writedata, src, save_dly} = '0;
    {rst, avs_read, avs_write, enable_interrupts_instr} = 4'h8;
    pins = 3'b111;
    tick(5);
    rst <= 1'b0;
    tick(1);
    bus(1'b1, 8'h20, 8'hFF);
    foreach (ridx[i]) rdchk(ridx[i], 8'h00);
    // edge select codes on pins a and c, pin b falling only
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, VIC_IDX_REQ, {2'(c), 6'h3F});
      @(posedge sys_clk);
      pins <= 3'b000;
      tick(3);
      rdchk(VIC_IDX_REQ, {2'(c), 3'b000, c != 2, 1'b1, c != 1});
      rdchk(VIC_IDX_PINS, 8'h00);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, VIC_IDX_REQ, {2'(c), 6'h3F});
      @(posedge sys_clk);
      pins <= 3'b111;
      tick(3);
      rdchk(VIC_IDX_REQ, {2'(c), 3'b000, c[1], 1'b0, c[0]});
    end
    @(posedge sys_clk);
    pins <= 3'b001;
    tick(2);
    rdchk(VIC_IDX_PINS, 8'h02);
    pins <= 3'b111;
    // internal and routed sources
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, VIC_IDX_REQ, 8'h3F);
      @(posedge sys_clk);
      src <= ev_src[i];
      @(posedge sys_clk);
      src <= '0;
      tick(3);
      rdchk(VIC_IDX_REQ, {2'b00, ev_exp[i]});
    end
    // masked, unmasked, global enable off
    bus(1'b1, VIC_IDX_REQ, 8'h3F);
    raise(6'h01);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, VIC_IDX_MASK, 8'h01);
    tick(2);
    chk({30'h0, irq, int_cycle}, 32'h2);
    bus(1'b1, VIC_IDX_MASK, 8'h00);
    pulse_ei;
    tick(3);
    chk({30'h0, irq, int_cycle}, 32'h0);
    rdchk(VIC_IDX_CTRL, 8'h01);
    bus(1'b1, VIC_IDX_CTRL, 8'h00);
    // priority over pending sets, prompt and slow core
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 8; s++) begin
        bus(1'b1, VIC_IDX_REQ, 8'h3F);
        raise(pats[p]);
        bus(1'b1, VIC_IDX_PRIO, 8'(s));
        bus(1'b1, VIC_IDX_MASK, 8'h3F);
        save_dly <= 4'(s);
        e = first(pats[p], s < 6 ? s : 0);
        pulse_ei;
        wait_branch(e);
        rdchk(VIC_IDX_REQ, {2'b00, pats[p] & ~(6'h01 << e)});
        rdchk(VIC_IDX_CTRL, 8'h00);
      end
    end
    // enable first, then comparator two and voltage detection raise their requests
    bus(1'b1, VIC_IDX_REQ, 8'h3F);
    bus(1'b1, VIC_IDX_MASK, 8'h21);
    pulse_ei;
    raise(6'h21);
    // enable again while the first cycle runs: the second grant waits for idle
    pulse_ei;
    wait_branch(0);
    wait_branch(5);
    results();
  end
endmodule : tb_vic_top
